// >>> src/rcc_div.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_div #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         en_in,
  input  wire logic [W-1:0] div,
  output logic              en_out
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] lim_reg;
  logic         first_reg;
  logic [W-1:0] lim;

  // live divisor until the first wrap, so no early pulse after reset
  assign lim = first_reg ? div : lim_reg;

  // divide by div+1; after the first wrap, new divisor only taken at wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg   <= '0;
      lim_reg   <= '0;
      first_reg <= 1'b1;
      en_out    <= 1'b0;
    end else begin
      en_out <= 1'b0;
      if (en_in) begin
        if (cnt_reg >= lim) begin
          cnt_reg   <= '0;
          lim_reg   <= div;
          first_reg <= 1'b0;
          en_out    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule : rcc_div
`default_nettype wire

// >>> src/rcc_pkg.sv
`default_nettype none
package rcc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ       = 20_000_000;
  localparam int RST_HOLD_NS  = 1000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HOLD_W       = 6;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] A_CLK_CFG   = 8'h00;
  localparam logic [7:0] A_PRE_DIV   = 8'h04;
  localparam logic [7:0] A_TICK_PLL  = 8'h08;
  localparam logic [7:0] A_TICK_XTAL = 8'h0C;
  localparam logic [7:0] A_TICK_APLL = 8'h10;
  localparam logic [7:0] A_TICK_OSC  = 8'h14;
  localparam logic [7:0] A_RST_CTRL  = 8'h18;
  localparam logic [7:0] A_CAUSE     = 8'h1C;

  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int SEL_LSB     = 0;
  localparam int PERIOD_BIT  = 2;
  localparam int LEDSEL_BIT  = 3;
  localparam int SWSYS_BIT   = 0;
  localparam int SWCPU0_BIT  = 1;
  localparam int SWCPU1_BIT  = 2;
  localparam int APPRST_BIT  = 3;
  localparam int CAUSE1_LSB  = 8;
  localparam int PRE_DIV_W   = 10;
  localparam int TICK_W      = 8;
  localparam int CAUSE_W     = 6;

  // ----------------------------------------
  // reset values and fixed divisors
  // ----------------------------------------
  localparam logic [PRE_DIV_W-1:0] PRE_DIV_RST = 10'h000;
  localparam logic [TICK_W-1:0]    TICK_RST    = 8'h00;
  localparam logic [7:0]           OSC_DIV_M1  = 8'hFF;
  localparam logic [PRE_DIV_W-1:0] PLL_DIV4_M1 = 10'h003;
  localparam logic [PRE_DIV_W-1:0] PLL_DIV2_M1 = 10'h001;

  typedef enum logic [1:0] {
    SRC_XTAL = 2'b00,
    SRC_PLL  = 2'b01,
    SRC_OSC  = 2'b10,
    SRC_APLL = 2'b11
  } rcc_src_t;

  // ----------------------------------------
  // reset cause codes
  // ----------------------------------------
  localparam logic [CAUSE_W-1:0] C_POR      = 6'h01;
  localparam logic [CAUSE_W-1:0] C_SW_SYS   = 6'h03;
  localparam logic [CAUSE_W-1:0] C_DSLEEP   = 6'h05;
  localparam logic [CAUSE_W-1:0] C_MAIN_WATCHDOG_0_G  = 6'h07;
  localparam logic [CAUSE_W-1:0] C_MAIN_WATCHDOG_1_G  = 6'h08;
  localparam logic [CAUSE_W-1:0] C_REALTIME_WATCHDOG_CO  = 6'h09;
  localparam logic [CAUSE_W-1:0] C_MWDT_CPU = 6'h0B;
  localparam logic [CAUSE_W-1:0] C_SW_CPU   = 6'h0C;
  localparam logic [CAUSE_W-1:0] C_REALTIME_WATCHDOG_CPU = 6'h0D;
  localparam logic [CAUSE_W-1:0] C_APP_RST  = 6'h0E;
  localparam logic [CAUSE_W-1:0] C_BROWNOUT = 6'h0F;
  localparam logic [CAUSE_W-1:0] C_REALTIME_WATCHDOG_SYS = 6'h10;

  // ----------------------------------------
  // peripheral clock permissions {plld2,apll,ledslow,ref,apb}
  // ----------------------------------------
  localparam int NPERIPH = 13;
  localparam logic [4:0] PERIPH_CLK_OK [NPERIPH] = '{
    5'h09, 5'h01, 5'h19, 5'h03, 5'h03, 5'h07, 5'h01,
    5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01
  };
endpackage : rcc_pkg
`default_nettype wire

// >>> src/rcc_top.sv
// Overview of operation
// - No reset level clears on-chip RAM; only registers are reset.
// - CPU-level reset touches only the affected core or cores.
// - Core-level reset resets all digital logic but not the always-on domain.
// - System-level reset resets everything, always-on domain included.
// - Each core has its own readable reset-cause field.
// - Some sources reset one core while the other keeps running and its cause.
// - System resets record 0x01 power-on, 0x10 watchdog system, 0x0F brown-out.
// - Software system reset is core-level, records 0x03; deep-sleep wake records 0x05.
// - Watchdog core-level resets record 0x07, 0x08, 0x09 in both cores.
// - CPU resets record 0x0B main watchdog, 0x0C software, 0x0D real-time watchdog.
// - Protocol core resetting the application core records 0xE for it only.
// - Source select: 0 crystal, 1 main PLL, 2 internal oscillator, 3 audio PLL.
// - Crystal or oscillator source: CPU clock is source over pre-divider plus one.
// - Main PLL source: period select 0 divides by four, else by two.
// - Audio PLL source: period select 0 divides by four, 1 by two.
// - Bus clock: PLL over four, audio CPU halved, else equal to CPU clock.
// - Reference tick divides bus clock by a per-source divider setting.
// - Slow clock is the internal oscillator divided by 256.
// - Main PLL is the high-speed source for CPU and peripheral clocks.
// - Peripherals may use only their permitted clocks.
// - LED slow clock: 1 selects oscillator, 0 selects bus clock.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rcc_top (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        xtal_tick,
  input  wire logic                        pll_tick,
  input  wire logic                        osc_tick,
  input  wire logic                        apll_tick,
  input  wire logic                        brownout_evt,
  input  wire logic                        realtime_watchdog_sys_evt,
  input  wire logic                        deep_sleep_wake_evt,
  input  wire logic                        main_watchdog_0_glob_evt,
  input  wire logic                        main_watchdog_1_glob_evt,
  input  wire logic                        realtime_watchdog_core_evt,
  input  wire logic                        main_watchdog_0_cpu_evt,
  input  wire logic                        main_watchdog_1_cpu_evt,
  input  wire logic                        realtime_watchdog_cpu_evt,
  input  wire logic [3:0]                  periph_sel,
  input  wire logic [2:0]                  clk_kind,
  output logic                             clk_kind_ok,
  output logic                             rtc_rst_n,
  output logic                             digital_rst_n,
  output logic                             core0_rst_n,
  output logic                             core1_rst_n,
  output logic                             cpu_clk_en,
  output logic                             apb_clk_en,
  output logic                             ref_tick,
  output logic                             led_pwm_slow_clock,
  output logic                             osc_div256_clock,
  output logic                             pll_half_clock,
  output logic                             audio_pll_clock,
  output logic [rcc_pkg::CAUSE_W-1:0]      core0_reset_cause,
  output logic [rcc_pkg::CAUSE_W-1:0]      core1_reset_cause
);
  import rcc_pkg::*;

  // ----------------------------------------
  // registers and wires
  // ----------------------------------------
  rcc_src_t              sel_reg;
  rcc_src_t              act_src_reg;
  logic                  period_reg;
  logic                  period_act_reg;
  logic                  led_sel_reg;
  logic [PRE_DIV_W-1:0]  pre_div_reg;
  logic [TICK_W-1:0]     tick_pll_reg;
  logic [TICK_W-1:0]     tick_xtal_reg;
  logic [TICK_W-1:0]     tick_apll_reg;
  logic [TICK_W-1:0]     tick_osc_reg;
  logic                  sw_sys_reg;
  logic                  sw_cpu0_reg;
  logic                  sw_cpu1_reg;
  logic                  app_ctl_reg;
  logic                  app_ctl_d_reg;
  logic                  wr_pend_reg;
  logic                  rd_pend_reg;
  logic [7:0]            addr_reg;
  logic [HOLD_W-1:0]     sys_cnt_reg;
  logic [HOLD_W-1:0]     core_cnt_reg;
  logic [HOLD_W-1:0]     cpu0_cnt_reg;
  logic [HOLD_W-1:0]     cpu1_cnt_reg;
  logic                  addr_ok;
  logic                  app_rise;
  logic                  sys_trig;
  logic                  core_trig;
  logic                  cpu0_trig;
  logic                  cpu1_trig;
  logic                  src_tick;
  logic [PRE_DIV_W-1:0]  cpu_div;
  logic [1:0]            apb_div;
  logic [TICK_W-1:0]     ref_div;
  logic [CAUSE_W-1:0]    glob_code;
  logic [31:0]           rd_mux;

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RST_HOLD_CYC);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign addr_ok   = hsel && htrans[1] && hready;
  assign hreadyout = !rd_pend_reg;
  assign hresp     = 1'b0;
  assign app_rise  = app_ctl_reg && !app_ctl_d_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      if (addr_ok) begin
        addr_reg <= {haddr[7:2], 2'b00};
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_reg)
      A_CLK_CFG:   rd_mux = {28'h0, led_sel_reg, period_reg, sel_reg};
      A_PRE_DIV:   rd_mux = {22'h0, pre_div_reg};
      A_TICK_PLL:  rd_mux = {24'h0, tick_pll_reg};
      A_TICK_XTAL: rd_mux = {24'h0, tick_xtal_reg};
      A_TICK_APLL: rd_mux = {24'h0, tick_apll_reg};
      A_TICK_OSC:  rd_mux = {24'h0, tick_osc_reg};
      A_RST_CTRL:  rd_mux = {28'h0, app_ctl_reg, 3'b000};
      A_CAUSE:     rd_mux = {18'h0, core1_reset_cause, 2'b00, core0_reset_cause};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg       <= SRC_XTAL;
      period_reg    <= 1'b0;
      led_sel_reg   <= 1'b0;
      pre_div_reg   <= PRE_DIV_RST;
      tick_pll_reg  <= TICK_RST;
      tick_xtal_reg <= TICK_RST;
      tick_apll_reg <= TICK_RST;
      tick_osc_reg  <= TICK_RST;
      app_ctl_reg   <= 1'b0;
    end else if (sys_trig || core_trig) begin
      sel_reg       <= SRC_XTAL;
      period_reg    <= 1'b0;
      led_sel_reg   <= 1'b0;
      pre_div_reg   <= PRE_DIV_RST;
      tick_pll_reg  <= TICK_RST;
      tick_xtal_reg <= TICK_RST;
      tick_apll_reg <= TICK_RST;
      tick_osc_reg  <= TICK_RST;
      app_ctl_reg   <= 1'b0;
    end else if (wr_pend_reg) begin
      case (addr_reg)
        A_CLK_CFG: begin
          sel_reg     <= rcc_src_t'(hwdata[SEL_LSB +: 2]);
          period_reg  <= hwdata[PERIOD_BIT];
          led_sel_reg <= hwdata[LEDSEL_BIT];
        end
        A_PRE_DIV:   pre_div_reg   <= hwdata[PRE_DIV_W-1:0];
        A_TICK_PLL:  tick_pll_reg  <= hwdata[TICK_W-1:0];
        A_TICK_XTAL: tick_xtal_reg <= hwdata[TICK_W-1:0];
        A_TICK_APLL: tick_apll_reg <= hwdata[TICK_W-1:0];
        A_TICK_OSC:  tick_osc_reg  <= hwdata[TICK_W-1:0];
        A_RST_CTRL:  app_ctl_reg   <= hwdata[APPRST_BIT];
        default: begin
        end
      endcase
    end
  end

  // software reset strobes, one cycle each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_sys_reg    <= 1'b0;
      sw_cpu0_reg   <= 1'b0;
      sw_cpu1_reg   <= 1'b0;
      app_ctl_d_reg <= 1'b0;
    end else begin
      sw_sys_reg    <= wr_pend_reg && addr_reg == A_RST_CTRL && hwdata[SWSYS_BIT];
      sw_cpu0_reg   <= wr_pend_reg && addr_reg == A_RST_CTRL && hwdata[SWCPU0_BIT];
      sw_cpu1_reg   <= wr_pend_reg && addr_reg == A_RST_CTRL && hwdata[SWCPU1_BIT];
      app_ctl_d_reg <= app_ctl_reg;
    end
  end

  // ----------------------------------------
  // reset levels
  // ----------------------------------------
  assign sys_trig  = brownout_evt || realtime_watchdog_sys_evt;
  assign core_trig = sw_sys_reg || deep_sleep_wake_evt || main_watchdog_0_glob_evt
                  || main_watchdog_1_glob_evt || realtime_watchdog_core_evt;
  assign cpu0_trig = main_watchdog_0_cpu_evt || sw_cpu0_reg || realtime_watchdog_cpu_evt;
  assign cpu1_trig = main_watchdog_1_cpu_evt || sw_cpu1_reg || realtime_watchdog_cpu_evt || app_rise;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_cnt_reg  <= HOLD_LOAD;
      core_cnt_reg <= '0;
      cpu0_cnt_reg <= '0;
      cpu1_cnt_reg <= '0;
    end else begin
      sys_cnt_reg  <= sys_trig  ? HOLD_LOAD : sys_cnt_reg  - HOLD_W'(sys_cnt_reg != '0);
      core_cnt_reg <= core_trig ? HOLD_LOAD : core_cnt_reg - HOLD_W'(core_cnt_reg != '0);
      cpu0_cnt_reg <= cpu0_trig ? HOLD_LOAD : cpu0_cnt_reg - HOLD_W'(cpu0_cnt_reg != '0);
      cpu1_cnt_reg <= cpu1_trig ? HOLD_LOAD : cpu1_cnt_reg - HOLD_W'(cpu1_cnt_reg != '0);
    end
  end

  // reset outputs only; memories get no clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rtc_rst_n     <= 1'b0;
      digital_rst_n <= 1'b0;
      core0_rst_n   <= 1'b0;
      core1_rst_n   <= 1'b0;
    end else begin
      rtc_rst_n     <= sys_cnt_reg == '0;
      digital_rst_n <= sys_cnt_reg == '0 && core_cnt_reg == '0;
      core0_rst_n   <= sys_cnt_reg == '0 && core_cnt_reg == '0
                    && cpu0_cnt_reg == '0;
      core1_rst_n   <= sys_cnt_reg == '0 && core_cnt_reg == '0
                    && cpu1_cnt_reg == '0 && !app_ctl_reg;
    end
  end

  // ----------------------------------------
  // reset cause
  // ----------------------------------------
  always_comb begin
    glob_code = '0;
    if (brownout_evt)             glob_code = C_BROWNOUT;
    else if (realtime_watchdog_sys_evt)        glob_code = C_REALTIME_WATCHDOG_SYS;
    else if (sw_sys_reg)          glob_code = C_SW_SYS;
    else if (deep_sleep_wake_evt) glob_code = C_DSLEEP;
    else if (main_watchdog_0_glob_evt)      glob_code = C_MAIN_WATCHDOG_0_G;
    else if (main_watchdog_1_glob_evt)      glob_code = C_MAIN_WATCHDOG_1_G;
    else if (realtime_watchdog_core_evt)       glob_code = C_REALTIME_WATCHDOG_CO;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core0_reset_cause <= C_POR;
    end else if (sys_trig || core_trig) begin
      core0_reset_cause <= glob_code;
    end else if (main_watchdog_0_cpu_evt) begin
      core0_reset_cause <= C_MWDT_CPU;
    end else if (sw_cpu0_reg) begin
      core0_reset_cause <= C_SW_CPU;
    end else if (realtime_watchdog_cpu_evt) begin
      core0_reset_cause <= C_REALTIME_WATCHDOG_CPU;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core1_reset_cause <= C_POR;
    end else if (sys_trig || core_trig) begin
      core1_reset_cause <= glob_code;
    end else if (main_watchdog_1_cpu_evt) begin
      core1_reset_cause <= C_MWDT_CPU;
    end else if (sw_cpu1_reg) begin
      core1_reset_cause <= C_SW_CPU;
    end else if (realtime_watchdog_cpu_evt) begin
      core1_reset_cause <= C_REALTIME_WATCHDOG_CPU;
    end else if (app_rise) begin
      core1_reset_cause <= C_APP_RST;
    end
  end

  // ----------------------------------------
  // clock tree
  // ----------------------------------------
  // selection moves only on a cpu clock boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_src_reg    <= SRC_XTAL;
      period_act_reg <= 1'b0;
    end else if (cpu_clk_en) begin
      act_src_reg    <= sel_reg;
      period_act_reg <= period_reg;
    end
  end

  always_comb begin
    src_tick = xtal_tick;
    cpu_div  = pre_div_reg;
    apb_div  = 2'd0;
    ref_div  = tick_xtal_reg;
    case (act_src_reg)
      SRC_XTAL: begin
        src_tick = xtal_tick;
      end
      SRC_PLL: begin
        src_tick = pll_tick;
        cpu_div  = period_act_reg ? PLL_DIV2_M1 : PLL_DIV4_M1;
        apb_div  = period_act_reg ? 2'd1 : 2'd0;
        ref_div  = tick_pll_reg;
      end
      SRC_OSC: begin
        src_tick = osc_tick;
        ref_div  = tick_osc_reg;
      end
      SRC_APLL: begin
        src_tick = apll_tick;
        cpu_div  = period_act_reg ? PLL_DIV2_M1 : PLL_DIV4_M1;
        apb_div  = 2'd1;
        ref_div  = tick_apll_reg;
      end
      default: begin
        src_tick = xtal_tick;
      end
    endcase
  end

  rcc_div #(.W(PRE_DIV_W)) u_cpu_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en_in   (src_tick),
    .div     (cpu_div),
    .en_out  (cpu_clk_en)
  );

  rcc_div #(.W(2)) u_apb_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en_in   (cpu_clk_en),
    .div     (apb_div),
    .en_out  (apb_clk_en)
  );

  rcc_div #(.W(TICK_W)) u_ref_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en_in   (apb_clk_en),
    .div     (ref_div),
    .en_out  (ref_tick)
  );

  rcc_div #(.W(8)) u_osc_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en_in   (osc_tick),
    .div     (OSC_DIV_M1),
    .en_out  (osc_div256_clock)
  );

  rcc_div #(.W(1)) u_half_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en_in   (pll_tick),
    .div     (1'b1),
    .en_out  (pll_half_clock)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_pwm_slow_clock <= 1'b0;
      audio_pll_clock    <= 1'b0;
    end else begin
      led_pwm_slow_clock <= led_sel_reg ? osc_tick : apb_clk_en;
      audio_pll_clock    <= apll_tick;
    end
  end

  assign clk_kind_ok = (int'(periph_sel) < NPERIPH) && (int'(clk_kind) < 5)
                    && PERIPH_CLK_OK[periph_sel][clk_kind];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [8:0] osc_seen_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_seen_reg <= 9'h000;
    end else if (osc_div256_clock) begin
      osc_seen_reg <= {8'h00, osc_tick};
    end else begin
      osc_seen_reg <= osc_seen_reg + {8'h00, osc_tick};
    end
  end

  property p_sys_cause;
    brownout_evt |=> core0_reset_cause == C_BROWNOUT && core1_reset_cause == C_BROWNOUT;
  endproperty
  a_sys_cause: assert property (p_sys_cause) else $error("brownout cause wrong");

  property p_sw_sys;
    sw_sys_reg && !sys_trig |=> core0_reset_cause == C_SW_SYS && core1_reset_cause == C_SW_SYS;
  endproperty
  a_sw_sys: assert property (p_sw_sys) else $error("software system cause wrong");

  property p_main_watchdog_0_glob;
    main_watchdog_0_glob_evt && !sys_trig && !sw_sys_reg && !deep_sleep_wake_evt
      |=> core0_reset_cause == C_MAIN_WATCHDOG_0_G && core1_reset_cause == C_MAIN_WATCHDOG_0_G;
  endproperty
  a_main_watchdog_0_glob: assert property (p_main_watchdog_0_glob) else $error("watchdog core cause wrong");

  property p_cpu0_only;
    main_watchdog_0_cpu_evt && !sys_trig && !core_trig && !cpu1_trig
      |=> core0_reset_cause == C_MWDT_CPU && $stable(core1_reset_cause);
  endproperty
  a_cpu0_only: assert property (p_cpu0_only) else $error("cpu reset cause wrong");

  property p_app_rst;
    app_rise && !sys_trig && !core_trig && !cpu0_trig && !main_watchdog_1_cpu_evt && !sw_cpu1_reg
      |=> core1_reset_cause == C_APP_RST && $stable(core0_reset_cause);
  endproperty
  a_app_rst: assert property (p_app_rst) else $error("app core cause wrong");

  property p_nest;
    !rtc_rst_n |-> !digital_rst_n && !core0_rst_n && !core1_rst_n;
  endproperty
  a_nest: assert property (p_nest) else $error("system reset not nested");

  property p_core_nest;
    !digital_rst_n |-> !core0_rst_n && !core1_rst_n;
  endproperty
  a_core_nest: assert property (p_core_nest) else $error("core reset not nested");

  property p_cpu_local;
    cpu0_trig && !cpu1_trig && !sys_trig && !core_trig && digital_rst_n && core1_rst_n
      && sys_cnt_reg == '0 && core_cnt_reg == '0 && cpu1_cnt_reg == '0 && !app_ctl_reg
      |=> ##1 !core0_rst_n && digital_rst_n && core1_rst_n;
  endproperty
  a_cpu_local: assert property (p_cpu_local) else $error("cpu reset leaked");

  property p_hold;
    !sys_trig && !core_trig && !cpu0_trig |=> $stable(core0_reset_cause);
  endproperty
  a_hold: assert property (p_hold) else $error("cause changed without reset");

  property p_div256;
    osc_div256_clock |-> osc_seen_reg == 9'h100;
  endproperty
  a_div256: assert property (p_div256) else $error("slow clock ratio wrong");

  c_brownout: cover property (brownout_evt ##1 !rtc_rst_n);
  c_app_rst:  cover property (app_rise ##2 !core1_rst_n && core0_rst_n);
  c_to_pll:   cover property (act_src_reg == SRC_XTAL ##1 act_src_reg == SRC_PLL);
  c_ref_tick: cover property (ref_tick && act_src_reg == SRC_PLL);
endmodule : rcc_top
`default_nettype wire

// >>> tb/rcc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_partner (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      xtal_tick,
  output logic      pll_tick,
  output logic      osc_tick,
  output logic      apll_tick
);
  logic ph_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ph_reg <= 1'b0;
    else ph_reg <= ~ph_reg;
  end
  assign pll_tick  = hresetn;
  assign osc_tick  = hresetn;
  assign xtal_tick = ph_reg;
  assign apll_tick = ~ph_reg;
endmodule : rcc_partner
`default_nettype wire

// >>> tb/rcc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_top_tb_top;
  import rcc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, rd, hreadyout, hresp, clk_kind_ok, rtc_rst_n, digital_rst_n;
  logic core0_rst_n, core1_rst_n, cpu_clk_en, apb_clk_en, ref_tick, led_pwm_slow_clock;
  logic osc_div256_clock, pll_half_clock, audio_pll_clock, xtal_tick, pll_tick, osc_tick, apll_tick;
  logic [1:0] htrans;
  logic [2:0] hsize, clk_kind;
  logic [3:0] periph_sel;
  logic [4:0] e5;
  logic [8:0] ev;
  logic [31:0] haddr, hwdata, hrdata;
  logic [5:0] core0_reset_cause, core1_reset_cause, c0e, c1e;
  logic [5:0] t0 [9] = '{6'h0F, 6'h10, 6'h05, 6'h07, 6'h08, 6'h09, 6'h0B, 6'h3F, 6'h0D};
  logic [5:0] t1 [9] = '{6'h0F, 6'h10, 6'h05, 6'h07, 6'h08, 6'h09, 6'h3F, 6'h0B, 6'h0D};
  logic [31:0] q [$];
  int failures, n_tests, seed, nc, na, nr, no, nl, nh, np, pd;
  rcc_top i_rcc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .xtal_tick, .pll_tick, .osc_tick,
    .apll_tick, .brownout_evt(ev[0]), .realtime_watchdog_sys_evt(ev[1]), .deep_sleep_wake_evt(ev[2]),
    .main_watchdog_0_glob_evt(ev[3]), .main_watchdog_1_glob_evt(ev[4]), .realtime_watchdog_core_evt(ev[5]),
    .main_watchdog_0_cpu_evt(ev[6]), .main_watchdog_1_cpu_evt(ev[7]), .realtime_watchdog_cpu_evt(ev[8]), .periph_sel,
    .clk_kind, .clk_kind_ok, .rtc_rst_n, .digital_rst_n, .core0_rst_n, .core1_rst_n,
    .cpu_clk_en, .apb_clk_en, .ref_tick, .led_pwm_slow_clock, .osc_div256_clock,
    .pll_half_clock, .audio_pll_clock, .core0_reset_cause, .core1_reset_cause);
  rcc_partner i_rcc_partner (.hclk, .hresetn, .xtal_tick, .pll_tick, .osc_tick, .apll_tick);
  // ----------------------------------------
  // bus and checking tasks
  // ----------------------------------------
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task wrdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 50) begin
      @(posedge hclk);
      i++;
    end
    if (i == 50) begin
      failures++;
      stop_test();
    end
  endtask : wrdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge hclk);
    if (!w) q.push_back(e);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wrdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; rd <= !w;
    wrdy();
    rd <= 1'b0;
  endtask : ahb
  always @(posedge hclk)
    if (rd && hreadyout === 1'b1) check(hrdata, q.pop_front());
  task clk(input logic [31:0] cfg, input int ec, input int ea, input int er);
    ahb(1'b1, A_CLK_CFG, cfg, 32'h0);
    repeat (60) @(posedge hclk);
    nc = 0; na = 0; nr = 0; no = 0; nl = 0; nh = 0; np = 0;
    repeat (512) begin
      @(posedge hclk);
      #1;
      nc += cpu_clk_en; na += apb_clk_en; nr += ref_tick; no += osc_div256_clock;
      nl += led_pwm_slow_clock; nh += pll_half_clock; np += audio_pll_clock;
    end
    check(nc, ec);
    check(na, ea);
    check(nr, er);
    check(no, 2);
    check(nl, cfg[3] ? 512 : ea);
    check(nh, 256);
    check(np, 256);
  endtask : clk
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    seed = 37; failures = 0; n_tests = 0; hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0; rd = 1'b0; ev = 9'h0;
    periph_sel = 4'h0; clk_kind = 3'h0; c0e = 6'h01; c1e = 6'h01;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, A_CAUSE, 32'h0, 32'h0000_0101);
    ahb(1'b0, 8'h3C, 32'h0, 32'h0);
    repeat (25) @(posedge hclk);
    // random divisor that splits the count window evenly
    pd = (1 << ($random(seed) & 3)) - 1;
    ahb(1'b1, A_PRE_DIV, pd, 32'h0);
    ahb(1'b0, A_PRE_DIV, 32'h0, pd);
    clk(32'h0, 256 / (pd + 1), 256 / (pd + 1), 256 / (pd + 1));
    ahb(1'b1, A_TICK_OSC, 32'h1, 32'h0);
    clk(32'h2, 512 / (pd + 1), 512 / (pd + 1), 256 / (pd + 1));
    ahb(1'b1, A_TICK_APLL, 32'h1, 32'h0);
    clk(32'h9, 128, 128, 128);
    clk(32'h5, 256, 128, 128);
    clk(32'h3, 64, 32, 16);
    $display("clock tests done");
    for (int p = 0; p < 14; p++) for (int k = 0; k < 6; k++) begin
      @(posedge hclk);
      periph_sel <= 4'(p); clk_kind <= 3'(k);
      e5 = 5'h01 | (p == 0 ? 5'h08 : 5'h0) | (p == 2 ? 5'h18 : 5'h0);
      e5 = p == 13 ? 5'h0 : e5 | (p > 2 && p < 6 ? 5'h02 : 5'h0) | (p == 5 ? 5'h04 : 5'h0);
      @(negedge hclk);
      check(clk_kind_ok, k < 5 ? e5[k] : 1'b0);
    end
    $display("clock permission test done");
    for (int k = 0; k < 9; k++) begin
      @(posedge hclk);
      ev <= 9'h1 << k;
      @(posedge hclk);
      ev <= 9'h0;
      @(posedge hclk);
      #1;
      if (t0[k] != 6'h3F) c0e = t0[k];
      if (t1[k] != 6'h3F) c1e = t1[k];
      check({rtc_rst_n, digital_rst_n, core0_rst_n, core1_rst_n}, {k > 1, k > 5, k == 7, k == 6});
      check({core1_reset_cause, core0_reset_cause}, {c1e, c0e});
      repeat (25) @(posedge hclk);
    end
    ahb(1'b1, A_RST_CTRL, 32'h1, 32'h0);
    repeat (4) @(posedge hclk);
    #1;
    check({digital_rst_n, core1_reset_cause, core0_reset_cause}, {1'b0, 6'h03, 6'h03});
    repeat (25) @(posedge hclk);
    ahb(1'b1, A_RST_CTRL, 32'h8, 32'h0);
    repeat (4) @(posedge hclk);
    #1;
    check({core1_rst_n, core1_reset_cause, core0_reset_cause}, {1'b0, 6'h0E, 6'h03});
    ahb(1'b0, A_CAUSE, 32'h0, 32'h0000_0E03);
    ahb(1'b1, A_RST_CTRL, 32'h0, 32'h0);
    $display("reset tests done");
    stop_test();
  end
endmodule : rcc_top_tb_top
`default_nettype wire
